// ==== core/dhwi_core.sv ====
/*
   host write interface of a 32-channel dac: serial frames with
   readback, two-wire slave (submodule) and strobed parallel port.
   assumes an outside register file answers RD_DATA combinationally
   for RD_CH/RD_SEL and consumes one-cycle WR_STB commands.
*/
`timescale 1ns/1ps
`include "dhwi_params.svh"
module dhwi_core import dhwi_pkg::*; #(
   parameter int unsigned FRAME_BITS = `DHWI_FRAME_BITS
) (
   input  wire logic        REF_CLK,
   input  wire logic        RST,
   input  wire logic        INTERFACE_TYPE_SELECT,
   input  wire logic        PROTOCOL_SELECT,
   input  wire logic        ADDRESS_STRAP_HIGH,
   input  wire logic        ADDRESS_STRAP_LOW,
   input  wire logic        SYNC_N,
   input  wire logic        SCLK,
   input  wire logic        DIN,
   output wire logic        SERIAL_READOUT_PIN,
   output wire logic        SERIAL_READOUT_OE,
   input  wire logic        SCL,
   input  wire logic        SDA_IN,
   output wire logic        SDA_OUT,
   output wire logic        SDA_OE,
   input  wire logic        CS_N,
   input  wire logic        WR_N,
   input  wire logic [4:0]  CHANNEL_ADDRESS_BITS,
   input  wire logic        REGISTER_SELECT_HIGH,
   input  wire logic        REGISTER_SELECT_LOW,
   input  wire logic [11:0] DAC_DATA_BITS,
   input  wire logic [11:0] RD_DATA,
   output wire logic [4:0]  RD_CH,
   output wire logic [1:0]  RD_SEL,
   output wire logic        WR_STB,
   output wire logic        WR_BANK,
   output wire logic [4:0]  WR_CH,
   output wire logic [1:0]  WR_SEL,
   output wire logic [11:0] WR_DATA
);
   localparam dhwi_pins_t PIN_IDLE = '{sync_n: 1'b1, scl: 1'b1, sda: 1'b1,
                                      cs_n: 1'b1, wr_n: 1'b1, default: '0};
   localparam logic [4:0] FRAME_LEN = 5'(`DHWI_FRAME_BITS);

   if (FRAME_BITS != `DHWI_FRAME_BITS) begin : g_frame_chk
      $error("only 24-bit serial frames are served");
   end
   if (`DHWI_I2C_CYC < `DHWI_MIN_SAMPLES) begin : g_rate_chk
      $error("clock too slow to sample a 400 kHz bus");
   end

   dhwi_top_t  c;
   dhwi_top_t  next_c;
   dhwi_pins_t p;
   dhwi_pins_t pins;
   logic       spi_en;
   logic       par_en;
   logic       sync_fall;
   logic       sync_rise;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       par_fire;
   logic       frame_ok;
   logic       sdo_ev;
   logic       hdr_msb;
   logic [23:0] word;

   dhwi_tw_if tw ();

   dhwi_i2c u_i2c (
      .clk (REF_CLK),
      .rst (RST),
      .tw  (tw.slave)
   );

   assign pins = '{its: INTERFACE_TYPE_SELECT, psel: PROTOCOL_SELECT,
                   strap: {ADDRESS_STRAP_HIGH, ADDRESS_STRAP_LOW},
                   sync_n: SYNC_N, sclk: SCLK, din: DIN, scl: SCL,
                   sda: SDA_IN, cs_n: CS_N, wr_n: WR_N,
                   ch: CHANNEL_ADDRESS_BITS,
                   sel: {REGISTER_SELECT_HIGH, REGISTER_SELECT_LOW},
                   db: DAC_DATA_BITS};
   assign p         = c.s2;
   assign spi_en    = p.its & ~p.psel;
   assign par_en    = ~p.its;
   assign sync_fall = c.sync_q & ~p.sync_n;
   assign sync_rise = ~c.sync_q & p.sync_n;
   assign sclk_rise = ~c.sclk_q & p.sclk;
   assign sclk_fall = c.sclk_q & ~p.sclk;
   assign par_fire  = par_en & ~c.wr_q & p.wr_n & ~p.cs_n;
   assign frame_ok  = spi_en & sync_rise & (c.icnt == FRAME_LEN);
   assign sdo_ev    = sclk_rise | sync_fall;
   assign hdr_msb   = c.hdr[9];
   // address echo, register value, two trailing zeros
   assign word      = c.pend ? {c.hdr, RD_DATA, 2'b00} : 24'h000000;

   // serial protocol select high hands the pins to the two-wire slave
   assign tw.en    = p.its & p.psel;
   assign tw.strap = p.strap;
   assign tw.scl   = p.scl;
   assign tw.sda   = p.sda;

   assign SERIAL_READOUT_PIN = c.serial_readout_pin;
   assign SERIAL_READOUT_OE  = c.sdo_oe;
   assign SDA_OUT            = c.sda_out;
   assign SDA_OE             = tw.sda_oe;
   assign RD_CH              = c.rd_ch;
   assign RD_SEL             = c.rd_sel;
   assign WR_STB             = c.wr.stb;
   assign WR_BANK            = c.wr.bank;
   assign WR_CH              = c.wr.ch;
   assign WR_SEL             = c.wr.sel;
   assign WR_DATA            = c.wr.data;

   always_comb begin
      next_c = c;
      next_c.s1 = pins;
      next_c.s2 = c.s1;
      next_c.sync_q = p.sync_n;
      next_c.sclk_q = p.sclk;
      next_c.wr_q = p.wr_n;
      next_c.wr.stb = 1'b0;
      next_c.sda_out = 1'b0;
      if (!spi_en) begin
         next_c.icnt = 5'h00;
         next_c.pend = 1'b0;
         next_c.sdo_oe = 1'b0;
      end else begin
         if (sync_fall) begin
            // a pending request is spent by this frame whatever it holds
            next_c.icnt = 5'h00;
            next_c.pend = 1'b0;
            next_c.sdo_oe = 1'b1;
            if (p.sclk) begin
               next_c.serial_readout_pin = word[23];
               next_c.osh = {word[22:0], 1'b0};
            end else begin
               next_c.serial_readout_pin = 1'b0;
               next_c.osh = word;
            end
         end else if (!p.sync_n) begin
            if (sclk_fall && c.icnt < FRAME_LEN) begin
               // bits past the 24th are ignored, not shifted
               next_c.ish = {c.ish[22:0], p.din};
               next_c.icnt = c.icnt + 5'h01;
            end
            if (sclk_rise) begin
               next_c.serial_readout_pin = c.osh[23];
               next_c.osh = {c.osh[22:0], 1'b0};
            end
         end
         if (sync_rise) begin
            next_c.sdo_oe = 1'b0;
         end
         // a short frame reaches neither branch and is dropped
         if (frame_ok) begin
            if (c.ish[`DHWI_BIT_RD]) begin
               next_c.pend = 1'b1;
               next_c.hdr = c.ish[`DHWI_HDR_HI:`DHWI_HDR_LO];
               next_c.rd_ch = c.ish[`DHWI_CH_HI:`DHWI_CH_LO];
               next_c.rd_sel = c.ish[`DHWI_SEL_HI:`DHWI_SEL_LO];
            end else if (c.ish != 24'h000000) begin
               // the all-zero frame only clocks readback out
               next_c.wr.stb = 1'b1;
               next_c.wr.bank = c.ish[`DHWI_HDR_HI];
               next_c.wr.ch = c.ish[`DHWI_CH_HI:`DHWI_CH_LO];
               next_c.wr.sel = c.ish[`DHWI_SEL_HI:`DHWI_SEL_LO];
               next_c.wr.data = c.ish[`DHWI_DAT_HI:`DHWI_DAT_LO];
            end
         end
      end
      if (par_fire) begin
         next_c.wr.stb = 1'b1;
         next_c.wr.bank = 1'b0;
         next_c.wr.ch = p.ch;
         next_c.wr.sel = p.sel;
         next_c.wr.data = p.db;
      end
      if (tw.wr.stb) begin
         next_c.wr = tw.wr;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         c <= '0;
         c.s1 <= PIN_IDLE;
         c.s2 <= PIN_IDLE;
         c.sync_q <= 1'b1;
         c.wr_q <= 1'b1;
      end else begin
         c <= next_c;
      end
   end

   a_short_frame: assert property (@(posedge REF_CLK) disable iff (RST)
      spi_en && sync_rise && c.icnt != FRAME_LEN |=> !WR_STB && !c.pend)
      else $error("short serial frame was used");
   a_read_capture: assert property (@(posedge REF_CLK) disable iff (RST)
      frame_ok && c.ish[`DHWI_BIT_RD]
      |=> !WR_STB && c.pend && RD_CH == $past(c.ish[`DHWI_CH_HI:`DHWI_CH_LO])
          && RD_SEL == $past(c.ish[`DHWI_SEL_HI:`DHWI_SEL_LO]))
      else $error("read request not captured");
   a_sdo_edges: assert property (@(posedge REF_CLK) disable iff (RST)
      $changed(SERIAL_READOUT_PIN) |-> $past(sdo_ev))
      else $error("readback bit moved off a rising edge");
   a_first_bit: assert property (@(posedge REF_CLK) disable iff (RST)
      spi_en && sync_fall && c.pend && p.sclk
      |=> SERIAL_READOUT_PIN == $past(hdr_msb) && SERIAL_READOUT_OE)
      else $error("first readback bit missing at sync fall");
   a_rd_word: assert property (@(posedge REF_CLK) disable iff (RST)
      spi_en && sync_fall && c.pend && !p.sclk
      |=> c.osh[23:14] == $past(c.hdr) && c.osh[13:2] == $past(RD_DATA)
          && !c.pend)
      else $error("readback word malformed");
   a_par_write: assert property (@(posedge REF_CLK) disable iff (RST)
      par_fire |=> WR_STB && WR_CH == $past(p.ch) && WR_DATA == $past(p.db)
                   && WR_SEL == $past(p.sel))
      else $error("parallel write not loaded");
   a_par_mode: assert property (@(posedge REF_CLK) disable iff (RST)
      !p.its [*2] |-> !SERIAL_READOUT_OE && !SDA_OE && !c.pend)
      else $error("serial port active in parallel mode");
   a_i2c_only_sda: assert property (@(posedge REF_CLK) disable iff (RST)
      SDA_OE |-> !SDA_OUT && $past(tw.en))
      else $error("data line driven outside two-wire mode");
endmodule : dhwi_core

// ==== core/dhwi_i2c.sv ====
/*
   receive-only two-wire slave: address match, pointer, data pairs,
   3-byte repeat and burst mode; emits one-cycle write commands.
   assumes scl and sda already pass two flip-flops in the core.
*/
`timescale 1ns/1ps
`include "dhwi_params.svh"
module dhwi_i2c import dhwi_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   dhwi_tw_if.slave tw
);
   dhwi_i2c_t c;
   dhwi_i2c_t next_c;
   logic      rise;
   logic      fall;
   logic      start;
   logic      stop;
   logic      active;
   logic      byte_end;

   // scl is only ever observed, the slave has no drive on it
   assign rise     = tw.scl & ~c.scl_q;
   assign fall     = ~tw.scl & c.scl_q;
   assign start    = tw.scl & c.scl_q & c.sda_q & ~tw.sda;
   assign stop     = tw.scl & c.scl_q & ~c.sda_q & tw.sda;
   assign active   = tw.en && c.st != I_IDLE && c.st != I_SKIP;
   assign byte_end = active && !start && !stop && fall && !c.in_ack
                     && c.cnt == 4'h8;
   assign tw.sda_oe = c.oe;
   assign tw.wr     = c.wr;

   always_comb begin
      next_c = c;
      next_c.wr.stb = 1'b0;
      next_c.scl_q = tw.scl;
      next_c.sda_q = tw.sda;
      if (!tw.en) begin
         next_c.st = I_IDLE;
         next_c.oe = 1'b0;
         next_c.burst = 1'b0;
      end else if (start) begin
         next_c.st = I_ADDR;
         next_c.cnt = 4'h0;
         next_c.in_ack = 1'b0;
         next_c.oe = 1'b0;
         next_c.burst = 1'b0;
      end else if (stop) begin
         // stop ends 3-byte and burst sequences alike
         next_c.st = I_IDLE;
         next_c.oe = 1'b0;
         next_c.burst = 1'b0;
      end else if (active) begin
         if (rise && !c.in_ack) begin
            next_c.sh = {c.sh[6:0], tw.sda};
            next_c.cnt = c.cnt + 4'h1;
         end
         if (fall && c.in_ack) begin
            next_c.oe = 1'b0;
            next_c.in_ack = 1'b0;
            next_c.cnt = 4'h0;
         end else if (byte_end) begin
            next_c.in_ack = 1'b1;
            next_c.oe = 1'b1;
            unique case (c.st)
               I_ADDR: begin
                  if (c.sh == {`DHWI_I2C_FIXED, tw.strap, 1'b0}) begin
                     next_c.st = I_PTR;
                  end else begin
                     // wrong address or read direction: stay off sda
                     next_c.oe = 1'b0;
                     next_c.st = I_SKIP;
                  end
               end
               I_PTR: begin
                  next_c.burst = c.sh == `DHWI_BURST_PTR;
                  next_c.ch = (c.sh == `DHWI_BURST_PTR) ? 5'h00
                                                       : c.sh[4:0];
                  next_c.st = I_DHI;
               end
               I_DHI: begin
                  next_c.hi = c.sh;
                  next_c.st = I_DLO;
               end
               I_DLO: begin
                  next_c.wr.stb = 1'b1;
                  next_c.wr.bank = c.burst ? 1'b0 : c.hi[7];
                  next_c.wr.ch = c.ch;
                  next_c.wr.sel = c.hi[5:4];
                  next_c.wr.data = {c.hi[3:0], c.sh};
                  if (c.burst && c.ch != `DHWI_LAST_CH) begin
                     next_c.ch = c.ch + 5'h01;
                     next_c.st = I_DHI;
                  end else begin
                     next_c.burst = 1'b0;
                     next_c.st = I_PTR;
                  end
               end
               default: next_c.st = I_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         c <= '0;
      end else begin
         c <= next_c;
      end
   end

   a_addr_ack: assert property (@(posedge clk) disable iff (rst)
      byte_end && c.st == I_ADDR
      && c.sh == {`DHWI_I2C_FIXED, tw.strap, 1'b0}
      |=> tw.sda_oe && c.st == I_PTR)
      else $error("matching address not acknowledged");
   a_data_ack: assert property (@(posedge clk) disable iff (rst)
      byte_end && c.st != I_ADDR |=> tw.sda_oe ##1 (tw.sda_oe || !tw.en))
      else $error("data byte not acknowledged");
   a_read_dir: assert property (@(posedge clk) disable iff (rst)
      byte_end && c.st == I_ADDR && c.sh[0] |=> !tw.sda_oe && c.st == I_SKIP)
      else $error("read direction answered");
   a_skip_quiet: assert property (@(posedge clk) disable iff (rst)
      c.st == I_SKIP |=> !tw.sda_oe && !c.wr.stb)
      else $error("foreign traffic driven");
   a_burst_start: assert property (@(posedge clk) disable iff (rst)
      byte_end && c.st == I_PTR && c.sh == `DHWI_BURST_PTR
      |=> c.burst && c.ch == 5'h00)
      else $error("burst pointer not at channel zero");
   a_burst_wrap: assert property (@(posedge clk) disable iff (rst)
      byte_end && c.st == I_DLO && c.burst && c.ch == `DHWI_LAST_CH
      |=> !c.burst && c.st == I_PTR && c.wr.stb)
      else $error("burst did not end after last channel");
   a_burst_bank: assert property (@(posedge clk) disable iff (rst)
      byte_end && c.st == I_DLO && c.burst |=> c.wr.stb && !c.wr.bank)
      else $error("bank select honoured in burst");
   a_three_byte: assert property (@(posedge clk) disable iff (rst)
      byte_end && c.st == I_DLO && !c.burst
      |=> c.st == I_PTR && c.wr.stb && c.wr.ch == $past(c.ch))
      else $error("3-byte repeat broken");
endmodule : dhwi_i2c

// ==== core/dhwi_params.svh ====
/*
   constants for the dac host write interface: serial frame layout,
   two-wire slave address, burst pointer and sampling figures.
   assumes inclusion by bare name from the design files.
*/
`ifndef DHWI_PARAMS_SVH
`define DHWI_PARAMS_SVH

`define DHWI_FRAME_BITS  24
`define DHWI_BIT_RD      22
`define DHWI_HDR_HI      23
`define DHWI_HDR_LO      14
`define DHWI_CH_HI       20
`define DHWI_CH_LO       16
`define DHWI_SEL_HI      15
`define DHWI_SEL_LO      14
`define DHWI_DAT_HI      13
`define DHWI_DAT_LO      2
`define DHWI_I2C_FIXED   5'h15
`define DHWI_BURST_PTR   8'hff
`define DHWI_LAST_CH     5'h1f
`define DHWI_CLK_KHZ     50000
`define DHWI_I2C_KHZ     400
`define DHWI_I2C_CYC     (`DHWI_CLK_KHZ / `DHWI_I2C_KHZ)
`define DHWI_MIN_SAMPLES 8

`endif

// ==== core/dhwi_pkg.sv ====
/*
   types of the dac host write interface: write command, pin sample,
   two-wire slave states and the state records of both modules.
   assumes nothing beyond a sv-2012 compiler.
*/
package dhwi_pkg;

   typedef struct packed {
      logic        stb;
      logic        bank;
      logic [4:0]  ch;
      logic [1:0]  sel;
      logic [11:0] data;
   } dhwi_wr_t;

   typedef struct packed {
      logic        its;
      logic        psel;
      logic [1:0]  strap;
      logic        sync_n;
      logic        sclk;
      logic        din;
      logic        scl;
      logic        sda;
      logic        cs_n;
      logic        wr_n;
      logic [4:0]  ch;
      logic [1:0]  sel;
      logic [11:0] db;
   } dhwi_pins_t;

   typedef enum logic [2:0] {
      I_IDLE, I_ADDR, I_PTR, I_DHI, I_DLO, I_SKIP
   } dhwi_i2c_st_t;

   typedef struct packed {
      dhwi_i2c_st_t st;
      logic         scl_q;
      logic         sda_q;
      logic [7:0]   sh;
      logic [3:0]   cnt;
      logic         in_ack;
      logic         oe;
      logic         burst;
      logic [4:0]   ch;
      logic [7:0]   hi;
      dhwi_wr_t     wr;
   } dhwi_i2c_t;

   typedef struct packed {
      dhwi_pins_t  s1;
      dhwi_pins_t  s2;
      logic        sync_q;
      logic        sclk_q;
      logic        wr_q;
      logic [23:0] ish;
      logic [4:0]  icnt;
      logic        pend;
      logic [9:0]  hdr;
      logic [23:0] osh;
      logic        serial_readout_pin;
      logic        sdo_oe;
      logic        sda_out;
      logic [4:0]  rd_ch;
      logic [1:0]  rd_sel;
      dhwi_wr_t    wr;
   } dhwi_top_t;

endpackage : dhwi_pkg

// ==== core/dhwi_tw_if.sv ====
/*
   link between the core and its two-wire slave: synchronised pins in,
   write commands and the data-line enable out.
   assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface dhwi_tw_if;
   import dhwi_pkg::*;
   logic       en;
   logic [1:0] strap;
   logic       scl;
   logic       sda;
   logic       sda_oe;
   dhwi_wr_t   wr;
   modport slave (input en, strap, scl, sda, output sda_oe, wr);
   modport core  (output en, strap, scl, sda, input sda_oe, wr);
endinterface : dhwi_tw_if

// ==== sim/dac_host_write_interface_test.sv ====
/*
   self-checking bench: parallel, framed serial with readback and
   two-wire writes including 3-byte repeat and burst.
   assumes the host model drives all host pins.
*/
`timescale 1ns/1ps
module dac_host_write_interface_test;
   import dhwi_pkg::*;
   logic ref_clk = 1'b0, rst = 1'b1, its = 1'b0, psel = 1'b0;
   logic [1:0]  strap = 2'b10;
   logic serial_readout_pin, sda_oe, sync_n, sclk, din, scl, sda_in, cs_n, wr_n;
   logic [4:0]  ch, rd_ch, wr_ch;
   logic [1:0]  sel, rd_sel, wr_sel;
   logic [11:0] db, rd_data, wr_data;
   logic        wr_stb, wr_bank, ack;
   logic        sdo_en, sdo_seen, sda_out, sda_pull;
   logic [19:0] last;
   logic [23:0] rx, fr;
   int miscompares = 0, check_count = 0, stb_n = 0, n0;
   always #10 ref_clk = ~ref_clk;
   dhwi_core DUT (.REF_CLK(ref_clk), .RST(rst),
      .INTERFACE_TYPE_SELECT(its), .PROTOCOL_SELECT(psel),
      .ADDRESS_STRAP_HIGH(strap[1]), .ADDRESS_STRAP_LOW(strap[0]),
      .SYNC_N(sync_n), .SCLK(sclk), .DIN(din),
      .SERIAL_READOUT_PIN(serial_readout_pin), .SERIAL_READOUT_OE(sdo_en), .SCL(scl),
      .SDA_IN(sda_in), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .CS_N(cs_n),
      .WR_N(wr_n), .CHANNEL_ADDRESS_BITS(ch),
      .REGISTER_SELECT_HIGH(sel[1]), .REGISTER_SELECT_LOW(sel[0]),
      .DAC_DATA_BITS(db), .RD_DATA(rd_data), .RD_CH(rd_ch),
      .RD_SEL(rd_sel), .WR_STB(wr_stb), .WR_BANK(wr_bank),
      .WR_CH(wr_ch), .WR_SEL(wr_sel), .WR_DATA(wr_data));
   // an undriven readback pin reads unknown, so a late enable shows up
   assign sdo_seen = sdo_en ? serial_readout_pin : 1'bx;
   // the line is pulled low only while the driven level is low
   assign sda_pull = sda_oe & ~sda_out;
   dhwi_host_model host (.clk(ref_clk), .serial_readout_pin(sdo_seen), .sda_oe(sda_pull),
      .rd_ch(rd_ch), .rd_sel(rd_sel), .sync_n(sync_n), .sclk(sclk),
      .din(din), .scl(scl), .sda_in(sda_in), .cs_n(cs_n), .wr_n(wr_n),
      .ch(ch), .sel(sel), .db(db), .rd_data(rd_data));
   // sampled on the falling edge so register updates have landed
   always @(negedge ref_clk) begin
      if (wr_stb === 1'b1) begin
         stb_n++;
         last = {wr_bank, wr_ch, wr_sel, wr_data};
      end
   end
   task automatic check(input string what, input logic [23:0] seen,
                        input logic [23:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic complete_run();
      if (miscompares == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : complete_run
   task automatic tw(input logic [7:0] b, input logic a_exp);
      host.tw_byte(b, ack);
      check("ack", ack, a_exp);
   endtask : tw
   initial begin
      #1_000_000;
      miscompares++;
      complete_run();
   end
   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      host.cyc(4);
      host.pwrite(1'b0, 5'h1f, 2'b10, 12'habc);
      check("par", last, {1'b0, 5'h1f, 2'b10, 12'habc});
      host.pwrite(1'b0, 5'h00, 2'b01, 12'h801);
      check("par0", last, {1'b0, 5'h00, 2'b01, 12'h801});
      n0 = stb_n;
      host.pwrite(1'b1, 5'h03, 2'b11, 12'h111);
      host.sframe(24'h8b_5a54, 24, rx);
      check("refused", stb_n, n0);
      its <= 1'b1;
      host.cyc(6);
      host.pwrite(1'b0, 5'h03, 2'b11, 12'h111);
      check("par off", stb_n, n0);
      fr = {1'b1, 1'b0, 1'b0, 5'h03, 2'b01, 12'h5a5, 2'b11};
      host.sframe(fr, 24, rx);
      check("ser", last, {1'b1, 5'h03, 2'b01, 12'h5a5});
      n0 = stb_n;
      host.sframe(24'h0b_ffff, 20, rx);
      check("short", stb_n, n0);
      fr = {1'b0, 1'b1, 1'b0, 5'h07, 2'b10, 12'hfff, 2'b00};
      host.sframe(fr, 24, rx);
      check("rd addr", {rd_ch, rd_sel}, {5'h07, 2'b10});
      check("rd nowr", stb_n, n0);
      host.sframe(24'h000000, 24, rx);
      check("readback", rx, {fr[23:14], 12'h807, 2'b00});
      check("nop", stb_n, n0);
      check("oe off", sdo_en, 1'b0);
      host.sclk_hi = 1'b0;
      fr = {1'b0, 1'b1, 1'b0, 5'h12, 2'b01, 12'h000, 2'b00};
      host.sframe(fr, 24, rx);
      host.sframe(24'h000000, 24, rx);
      check("readback lo", rx, {fr[23:14], 12'h412, 2'b00});
      check("nop lo", stb_n, n0);
      host.sclk_hi = 1'b1;
      psel <= 1'b1;
      host.cyc(6);
      host.tw_start();
      tw(8'hac, 1'b1);
      tw(8'h09, 1'b1);
      tw(8'hb1, 1'b1);
      tw(8'h23, 1'b1);
      check("tw", last, {1'b1, 5'h09, 2'b11, 12'h123});
      tw(8'h02, 1'b1);
      tw(8'h4f, 1'b1);
      tw(8'hff, 1'b1);
      check("tw rep", last, {1'b0, 5'h02, 2'b00, 12'hfff});
      tw(8'hff, 1'b1);
      for (int i = 0; i < 32; i++) begin
         tw(8'h90, 1'b1);
         tw(8'(i), 1'b1);
         check("burst", last, {1'b0, 5'(i), 2'b01, 12'(i)});
      end
      tw(8'h04, 1'b1);
      tw(8'h20, 1'b1);
      tw(8'h55, 1'b1);
      check("tw ptr", last, {1'b0, 5'h04, 2'b10, 12'h055});
      host.tw_stop();
      n0 = stb_n;
      host.tw_start();
      tw(8'haa, 1'b0);
      tw(8'h01, 1'b0);
      tw(8'h00, 1'b0);
      tw(8'h00, 1'b0);
      host.tw_stop();
      host.tw_start();
      tw(8'had, 1'b0);
      tw(8'h01, 1'b0);
      host.tw_stop();
      check("tw foreign", stb_n, n0);
      strap <= 2'b01;
      host.cyc(6);
      host.tw_start();
      tw(8'haa, 1'b1);
      host.tw_stop();
      complete_run();
   end
endmodule : dac_host_write_interface_test

// ==== sim/dhwi_host_model.sv ====
/*
   host-side model: drives framed serial, two-wire and parallel pins,
   and answers register reads from a fixed pattern.
   assumes the bench owns reset and the interface select pins.
*/
`timescale 1ns/1ps
module dhwi_host_model (
   input  wire logic        clk,
   input  wire logic        serial_readout_pin,
   input  wire logic        sda_oe,
   input  wire logic [4:0]  rd_ch,
   input  wire logic [1:0]  rd_sel,
   output logic             sync_n,
   output logic             sclk,
   output logic             din,
   output logic             scl,
   output wire logic        sda_in,
   output logic             cs_n,
   output logic             wr_n,
   output logic [4:0]  ch,
   output logic [1:0]  sel,
   output logic [11:0] db,
   output wire logic [11:0] rd_data
);
   logic sda_h;
   // level of the serial clock at sync fall and between bits, set by the bench
   logic sclk_hi = 1'b1;
   // pull-up: the line is low only when someone pulls it
   assign sda_in  = sda_h & ~sda_oe;
   assign rd_data = {rd_sel, 5'h00, rd_ch};
   initial begin
      {sync_n, sclk, din, scl, sda_h, cs_n, wr_n} = 7'h7f;
      {ch, sel, db} = '0;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   // clock idles at sclk_hi within the frame; sync stays low over the whole frame
   task automatic sframe(input logic [23:0] f, input int n,
                         output logic [23:0] rx);
      rx = '0;
      sync_n <= 1'b0;
      sclk   <= sclk_hi;
      for (int i = 0; i < n; i++) begin
         din <= f[23-i];
         // idling low: the rise that clocks the bit out comes first
         if (!sclk_hi) begin
            cyc(4);
            sclk <= 1'b1;
         end
         cyc(3);
         @(negedge clk) rx[23-i] = serial_readout_pin;
         @(posedge clk) sclk <= 1'b0;
         cyc(4);
         if (sclk_hi) begin
            sclk <= 1'b1;
         end
      end
      cyc(4);
      sync_n <= 1'b1;
      cyc(4);
      sclk <= 1'b1;
      cyc(6);
   endtask : sframe
   task automatic tw_start();
      sda_h <= 1'b0;
      cyc(8);
      scl <= 1'b0;
      cyc(8);
   endtask : tw_start
   task automatic tw_stop();
      sda_h <= 1'b0;
      cyc(8);
      scl <= 1'b1;
      cyc(8);
      sda_h <= 1'b1;
      cyc(8);
   endtask : tw_stop
   task automatic tw_byte(input logic [7:0] b, output logic ack);
      for (int i = 0; i < 9; i++) begin
         sda_h <= (i < 8) ? b[7-i] : 1'b1;
         cyc(8);
         scl <= 1'b1;
         cyc(7);
         @(negedge clk) if (i == 8) ack = (sda_in === 1'b0);
         @(posedge clk) scl <= 1'b0;
         cyc(8);
      end
   endtask : tw_byte
   task automatic pwrite(input logic c, input logic [4:0] a,
                         input logic [1:0] s, input logic [11:0] d);
      cs_n <= c;
      {ch, sel, db} <= {a, s, d};
      wr_n <= 1'b0;
      cyc(4);
      wr_n <= 1'b1;
      cyc(4);
      cs_n <= 1'b1;
      cyc(8);
   endtask : pwrite
endmodule : dhwi_host_model
